// >>> bench/estb_partner.sv
// far-side model: stop loops, reset button, brake drive, relay, supply
`timescale 1ns/1ps
module estb_partner (
    input wire logic ref_clk,
    output logic inner_stop_loop,
    output logic outer_stop_loop,
    output logic reset_loop,
    output logic brake_one_request,
    output logic brake_two_request,
    output logic relay_control,
    output logic under_voltage
);
    initial
    begin
        inner_stop_loop = 1'b1;
        outer_stop_loop = 1'b1;
        reset_loop = 1'b0;
        brake_one_request = 1'b0;
        brake_two_request = 1'b0;
        relay_control = 1'b0;
        under_voltage = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////
    // loops held closed only while a clear stop is wanted
    task automatic set_loops(input logic inr, input logic otr);
        @(posedge ref_clk);
        inner_stop_loop <= inr;
        outer_stop_loop <= otr;
    endtask
    // momentary closure, longer than the pin qualifier window
    task automatic press_reset();
        @(posedge ref_clk);
        reset_loop <= 1'b1;
        repeat (6) @(posedge ref_clk);
        reset_loop <= 1'b0;
    endtask
    // one request line per brake, as a drive output supplies
    task automatic set_pins(input logic b1, b2, rc, uv);
        @(posedge ref_clk);
        brake_one_request <= b1;
        brake_two_request <= b2;
        relay_control <= rc;
        under_voltage <= uv;
    endtask
endmodule // estb_partner

// >>> bench/estb_top_tb.sv
// self-checking bench for the stop, brake and relay interlock
`timescale 1ns/1ps
module estb_top_tb;
    import estb_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [DATA_W-1:0] avs_writedata = '0;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    logic [SW_W-1:0] sw = '0;
    logic in_l, out_l, rst_l, b1, b2, rc, uv;
    logic b1_o, b2_o, lo_o, rly_o, uv_o, irq;
    logic [DATA_W-1:0] rd;
    int n_errors = 0;
    int n_checks = 0;

    always #10 ref_clk = ~ref_clk;

    estb_top dut (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .config_switch_bank(sw),
        .inner_stop_loop(in_l), .outer_stop_loop(out_l),
        .reset_loop(rst_l), .brake_one_request(b1),
        .brake_two_request(b2), .relay_control(rc), .under_voltage(uv),
        .brake_one_output(b1_o), .brake_two_output(b2_o),
        .stop_state_logic_output(lo_o), .relay_contact_closed(rly_o),
        .under_voltage_flag(uv_o), .irq(irq));

    estb_partner part (.ref_clk(ref_clk), .inner_stop_loop(in_l),
        .outer_stop_loop(out_l), .reset_loop(rst_l),
        .brake_one_request(b1), .brake_two_request(b2),
        .relay_control(rc), .under_voltage(uv));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !wr;
        avs_write <= wr;
        do
            @(posedge ref_clk);
        while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    // pin path is about five edges deep
    task automatic settle();
        repeat (8) @(posedge ref_clk);
    endtask
    task automatic chk_power(input logic exp);
        settle();
        bus(1'b0, OFS_STATUS, 32'h0);
        check("power", rd[ST_POWER], exp);
        check("logic_out", lo_o, exp & sw[SW_LOGIC]);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        void'($urandom(93735));
        repeat (8) @(posedge ref_clk);
        resetn <= 1'b1;
        bus(1'b0, OFS_IRQ_MASK, 32'h0);
        check("mask_rst", rd, 32'h0);
        bus(1'b0, 4'h2, 32'h0);
        check("unmapped", rd, 32'h0);
        // brake polarity and plain relay path, corners first
        for (int i = 0; i < 12; i++)
        begin
            logic [2:0] r;
            r = (i < 8) ? i[2:0] : 3'($urandom);
            sw <= {5'h00, r[2], 1'b0};
            part.set_pins(r[0], r[1], r[0] ^ r[1], 1'b0);
            settle();
            check("brake_one_output", b1_o, r[0] == r[2]);
            check("brake_two_output", b2_o, r[1] == r[2]);
            check("relay", rly_o, r[0] ^ r[1]);
        end
        // reset mode off: power tracks only the enabled loops
        sw <= 7'h34;
        chk_power(1'b1);
        part.set_loops(1'b0, 1'b1);
        chk_power(1'b0);
        part.set_loops(1'b1, 1'b0);
        chk_power(1'b0);
        sw <= 7'h14;
        chk_power(1'b1);
        sw <= 7'h24;
        part.set_loops(1'b0, 1'b1);
        chk_power(1'b1);
        // relay opened by an active stop only when so configured
        sw <= 7'h34;
        part.set_pins(1'b0, 1'b0, 1'b1, 1'b0);
        settle();
        check("relay_free", rly_o, 1'b1);
        sw <= 7'h3C;
        settle();
        check("relay_stop", rly_o, 1'b0);
        part.set_loops(1'b1, 1'b1);
        chk_power(1'b1);
        check("relay_clear", rly_o, 1'b1);
        sw <= 7'h38;
        chk_power(1'b1);
        // reset mode on: loops alone never restore power
        sw <= 7'h3D;
        part.set_loops(1'b0, 1'b1);
        chk_power(1'b0);
        part.set_loops(1'b1, 1'b1);
        chk_power(1'b0);
        part.press_reset();
        chk_power(1'b1);
        part.set_loops(1'b0, 1'b1);
        part.press_reset();
        part.set_loops(1'b1, 1'b1);
        chk_power(1'b0);
        // stop-rise interrupt: raise, mask, clear
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        settle();
        check("irq_idle", irq, 1'b0);
        part.set_loops(1'b0, 1'b1);
        settle();
        check("irq_set", irq, 1'b1);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        check("stat_stop", rd[IRQ_STOP], 1'b1);
        bus(1'b1, OFS_IRQ_MASK, 32'h0);
        settle();
        check("irq_mask", irq, 1'b0);
        bus(1'b1, OFS_IRQ_MASK, 32'h1);
        bus(1'b1, OFS_IRQ_STAT, 32'h1);
        settle();
        check("irq_clr", irq, 1'b0);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        check("stat_clr", rd[IRQ_STOP], 1'b0);
        // under-voltage reported only with the monitor on
        sw <= 7'h40;
        part.set_pins(1'b0, 1'b0, 1'b0, 1'b1);
        settle();
        check("uv_on", uv_o, 1'b1);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        check("stat_uv", rd[IRQ_UV], 1'b1);
        sw <= 7'h00;
        settle();
        check("uv_off", uv_o, 1'b0);
        // software stop holds power off until released
        bus(1'b1, OFS_IRQ_STAT, 32'h7);
        bus(1'b1, OFS_CTRL, 32'h1);
        chk_power(1'b0);
        bus(1'b0, OFS_CTRL, 32'h0);
        check("ctrl", rd, 32'h1);
        bus(1'b1, OFS_CTRL, 32'h0);
        chk_power(1'b1);
        bus(1'b0, OFS_IRQ_STAT, 32'h0);
        check("stat_pwr", rd[IRQ_POWER], 1'b1);
        report_and_stop();
    end
endmodule // estb_top_tb

// >>> logic/estb_pkg.sv
// constants and types shared by the stop, brake and relay interlock
package estb_pkg;

    // avalon slave geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // register byte offsets
    localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
    localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h8;
    localparam logic [ADDR_W-1:0] OFS_CTRL = 4'hC;

    // switch bank bit positions
    localparam int SW_W = 7;
    localparam int SW_RESET = 0;
    localparam int SW_POL = 1;
    localparam int SW_LOGIC = 2;
    localparam int SW_RELAY = 3;
    localparam int SW_INNER = 4;
    localparam int SW_OUTER = 5;
    localparam int SW_UV = 6;

    // positions of the pin inputs in the synchroniser vector
    localparam int IN_INNER = 7;
    localparam int IN_OUTER = 8;
    localparam int IN_RESET = 9;
    localparam int IN_BRK1 = 10;
    localparam int IN_BRK2 = 11;
    localparam int IN_RELAY = 12;
    localparam int IN_UV = 13;
    localparam int IN_W = 14;

    // interrupt status and mask layout
    localparam int IRQ_W = 3;
    localparam int IRQ_STOP = 0;
    localparam int IRQ_UV = 1;
    localparam int IRQ_POWER = 2;

    // status register field positions
    localparam int ST_POWER = 0;
    localparam int ST_STOP = 1;
    localparam int ST_UV = 2;
    localparam int ST_BRK1 = 3;
    localparam int ST_BRK2 = 4;
    localparam int ST_RELAY = 5;
    localparam int ST_SW_LSB = 8;

    // control register fields
    localparam int CTRL_SOFT_STOP = 0;

    // reset values
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [IN_W-1:0] SYNC_RST = 14'h0000;

    typedef enum logic [1:0] {
        PWR_OFF = 2'b01,
        PWR_ON = 2'b10
    } estb_pwr_e;

endpackage

// >>> logic/estb_sync.sv
// three-stage pin synchroniser with agreement qualifier
`timescale 1ns/1ps
module estb_sync
    import estb_pkg::*;
#(
    parameter int W = 14
)(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    estb_sync_if.filt pins
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] clean;
    } estb_sync_s;

    estb_sync_s state_ff;
    estb_sync_s nxt_state;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        if (clk_en)
        begin
            nxt_state.s1 = pins.raw;
            nxt_state.s2 = state_ff.s1;
            nxt_state.s3 = state_ff.s2;
            // only bits where stage two and three agree may change
            nxt_state.clean = (state_ff.s2 & ~(state_ff.s2 ^ state_ff.s3))
                | (state_ff.clean & (state_ff.s2 ^ state_ff.s3));
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
            state_ff <= '0;
        else
            state_ff <= nxt_state;
    end

    assign pins.clean = state_ff.clean;

endmodule // estb_sync

// >>> logic/estb_sync_if.sv
// raw pin levels in, qualified levels out, between top and synchroniser
`timescale 1ns/1ps
interface estb_sync_if #(parameter int W = 14);
    logic [W-1:0] raw;
    logic [W-1:0] clean;
    modport owner (output raw, input clean);
    modport filt (input raw, output clean);
endinterface

// >>> logic/estb_top.sv
// stop loop, motor power, brake and relay interlock with avalon registers
//
// What this block does
// - reset mode on: power returns only after reset pulse with loops clear
// - each brake output active when its request is at the chosen level
// - logic output follows motor power when enabled, otherwise false
// - relay mode on: relay contact open while a stop event is active
// - inner loop enabled: it must be closed for the stop to clear
// - outer loop enabled: it must be closed for the stop to clear
// - under-voltage is flagged and reported only when monitoring enabled
// - relay contact follows its dedicated control input as well
`timescale 1ns/1ps
module estb_top (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [estb_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [estb_pkg::DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [estb_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [estb_pkg::SW_W-1:0] config_switch_bank,
    input wire logic inner_stop_loop,
    input wire logic outer_stop_loop,
    input wire logic reset_loop,
    input wire logic brake_one_request,
    input wire logic brake_two_request,
    input wire logic relay_control,
    input wire logic under_voltage,
    output logic brake_one_output,
    output logic brake_two_output,
    output logic stop_state_logic_output,
    output logic relay_contact_closed,
    output logic under_voltage_flag,
    output logic irq
);
    import estb_pkg::*;

    typedef struct packed {
        estb_pwr_e pwr;
        logic live;
        logic rst_prev;
        logic stop_prev;
        logic uv_prev;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic soft_stop;
        logic ack;
        logic [DATA_W-1:0] rdata;
        logic logic_out;
        logic relay_closed;
        logic [1:0] brake;
        logic uv_flag;
        logic irq;
    } estb_top_s;

    estb_top_s state_ff;
    estb_top_s nxt_state;

    // a disabled loop counts as closed
    function automatic logic loop_ok(input logic used, input logic closed);
        return !used || closed;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin qualification

    estb_sync_if #(.W(IN_W)) sync_bus ();

    assign sync_bus.raw = {under_voltage, relay_control, brake_two_request,
        brake_one_request, reset_loop, outer_stop_loop, inner_stop_loop,
        config_switch_bank};

    estb_sync #(.W(IN_W)) u_sync (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pins(sync_bus.filt)
    );

    logic [IN_W-1:0] q;
    logic [SW_W-1:0] sw;
    logic stop_active;
    logic rst_edge;
    logic uv_now;
    logic bus_req;
    logic wr_go;
    logic rd_go;
    logic pwr_up;
    logic [IRQ_W-1:0] irq_set;
    logic [IRQ_W-1:0] irq_clr;

    assign q = sync_bus.clean;
    assign sw = q[SW_W-1:0];

    // switches read zero after reset, so both loops count as closed and no stop is active
    assign stop_active = !(loop_ok(sw[SW_INNER], q[IN_INNER])
        && loop_ok(sw[SW_OUTER], q[IN_OUTER]))
        || state_ff.soft_stop;
    // momentary closure counted on its closing edge only
    assign rst_edge = q[IN_RESET] && !state_ff.rst_prev;
    assign uv_now = sw[SW_UV] && q[IN_UV];

    ////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait state, answer on the second edge

    assign bus_req = avs_read || avs_write;
    assign avs_waitrequest = bus_req && !state_ff.ack;
    assign wr_go = avs_write && state_ff.ack && clk_en;
    assign rd_go = avs_read && !state_ff.ack;
    assign avs_readdata = state_ff.rdata;

    // taken from state, so no loop through the next-state copy
    assign pwr_up = state_ff.pwr == PWR_OFF && !stop_active
        && (!sw[SW_RESET] || rst_edge);
    assign irq_set = {pwr_up, uv_now && !state_ff.uv_prev,
        stop_active && !state_ff.stop_prev};
    assign irq_clr = (wr_go && avs_address == OFS_IRQ_STAT
        && avs_byteenable[0]) ? avs_writedata[IRQ_W-1:0] : '0;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        nxt_state = state_ff;
        if (clk_en)
        begin
            nxt_state.live = 1'b1;
            nxt_state.rst_prev = q[IN_RESET];
            nxt_state.stop_prev = stop_active;
            nxt_state.uv_prev = uv_now;
            nxt_state.ack = bus_req && !state_ff.ack;

            // motor power sequencing
            case (state_ff.pwr)
                PWR_OFF:
                begin
                    if (!stop_active && !sw[SW_RESET])
                        nxt_state.pwr = PWR_ON;
                    else if (!stop_active && rst_edge)
                        nxt_state.pwr = PWR_ON;
                end
                PWR_ON:
                begin
                    if (stop_active)
                        nxt_state.pwr = PWR_OFF;
                end
                default:
                    nxt_state.pwr = PWR_OFF;
            endcase

            // outputs
            nxt_state.logic_out = sw[SW_LOGIC]
                && nxt_state.pwr == PWR_ON;
            nxt_state.relay_closed = q[IN_RELAY]
                && !(sw[SW_RELAY] && stop_active);
            // requests come in separately per brake
            nxt_state.brake[0] = sw[SW_POL] ? q[IN_BRK1] : !q[IN_BRK1];
            nxt_state.brake[1] = sw[SW_POL] ? q[IN_BRK2] : !q[IN_BRK2];
            nxt_state.uv_flag = uv_now;

            // set wins over a clear in the same cycle
            nxt_state.irq_stat = (state_ff.irq_stat & ~irq_clr) | irq_set;

            if (wr_go && avs_byteenable[0])
            begin
                case (avs_address)
                    OFS_IRQ_MASK:
                        nxt_state.irq_mask = avs_writedata[IRQ_W-1:0];
                    OFS_CTRL:
                        nxt_state.soft_stop = avs_writedata[CTRL_SOFT_STOP];
                    default:
                        nxt_state.soft_stop = state_ff.soft_stop;
                endcase
            end

            if (rd_go)
            begin
                case (avs_address)
                    OFS_STATUS:
                    begin
                        nxt_state.rdata = '0;
                        nxt_state.rdata[ST_POWER] = state_ff.pwr == PWR_ON;
                        nxt_state.rdata[ST_STOP] = stop_active;
                        nxt_state.rdata[ST_UV] = state_ff.uv_flag;
                        nxt_state.rdata[ST_BRK1] = state_ff.brake[0];
                        nxt_state.rdata[ST_BRK2] = state_ff.brake[1];
                        nxt_state.rdata[ST_RELAY] = state_ff.relay_closed;
                        nxt_state.rdata[ST_SW_LSB +: SW_W] = sw;
                    end
                    OFS_IRQ_STAT:
                        nxt_state.rdata = {{(DATA_W-IRQ_W){1'b0}},
                            state_ff.irq_stat};
                    OFS_IRQ_MASK:
                        nxt_state.rdata = {{(DATA_W-IRQ_W){1'b0}},
                            state_ff.irq_mask};
                    OFS_CTRL:
                        nxt_state.rdata = {{(DATA_W-1){1'b0}},
                            state_ff.soft_stop};
                    default:
                        nxt_state.rdata = '0;
                endcase
            end

            // level output, stays high until cleared or masked
            nxt_state.irq = |(nxt_state.irq_stat & nxt_state.irq_mask);
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            state_ff <= '0;
            state_ff.pwr <= PWR_OFF;
            state_ff.irq_mask <= IRQ_MASK_RST;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    assign brake_one_output = state_ff.brake[0];
    assign brake_two_output = state_ff.brake[1];
    assign stop_state_logic_output = state_ff.logic_out;
    assign relay_contact_closed = state_ff.relay_closed;
    assign under_voltage_flag = state_ff.uv_flag;
    assign irq = state_ff.irq;

    ////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);

    property p_stop_kills_power;
        clk_en && stop_active |=> state_ff.pwr == PWR_OFF;
    endproperty
    a_stop_kills_power: assert property (p_stop_kills_power)
        else $error("power stayed on during a stop event");

    property p_reset_needed;
        clk_en && sw[SW_RESET] && state_ff.pwr == PWR_OFF && !rst_edge
            |=> state_ff.pwr == PWR_OFF;
    endproperty
    a_reset_needed: assert property (p_reset_needed)
        else $error("power came on without a reset closure");

    property p_reset_restores;
        clk_en && sw[SW_RESET] && !stop_active && rst_edge
            |=> state_ff.pwr == PWR_ON;
    endproperty
    a_reset_restores: assert property (p_reset_restores)
        else $error("reset closure did not restore power");

    property p_auto_power;
        clk_en && state_ff.live && !sw[SW_RESET] && !stop_active
            |=> state_ff.pwr == PWR_ON;
    endproperty
    a_auto_power: assert property (p_auto_power)
        else $error("power not restored in auto mode");

    property p_logic_follows;
        clk_en |=> stop_state_logic_output
            == ($past(sw[SW_LOGIC]) && state_ff.pwr == PWR_ON);
    endproperty
    a_logic_follows: assert property (p_logic_follows)
        else $error("logic output does not follow power");

    property p_relay_open;
        clk_en && sw[SW_RELAY] && stop_active |=> !relay_contact_closed;
    endproperty
    a_relay_open: assert property (p_relay_open)
        else $error("relay closed during stop event");

    property p_relay_ctl;
        clk_en && !q[IN_RELAY] |=> !relay_contact_closed;
    endproperty
    a_relay_ctl: assert property (p_relay_ctl)
        else $error("relay closed without control input");

    property p_brake_pol;
        clk_en && state_ff.live |=> brake_one_output == ($past(q[IN_BRK1])
            == $past(sw[SW_POL])) && brake_two_output
            == ($past(q[IN_BRK2]) == $past(sw[SW_POL]));
    endproperty
    a_brake_pol: assert property (p_brake_pol)
        else $error("brake output has wrong polarity");

    property p_uv_off;
        clk_en && !sw[SW_UV] |-> !irq_set[IRQ_UV] ##1 !under_voltage_flag;
    endproperty
    a_uv_off: assert property (p_uv_off)
        else $error("under-voltage reported while monitor off");

    property p_bus_answer;
        clk_en && bus_req && avs_waitrequest |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered after one wait state");

endmodule // estb_top
